//--- qce_enc_model.sv
// Behavioural incremental encoder producing A and B tracks.
module qce_enc_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic step,
  input wire logic step_dir,
  output logic phase_a,
  output logic phase_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_reg;
  // A forward step moves the tracks through 00, 10, 11, 01 (A, B).
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pos_reg <= 2'h0;
    end else if (step) begin
      pos_reg <= step_dir ? pos_reg + 2'h1 : pos_reg - 2'h1;
    end
  end
  // Gray coding keeps the tracks in quadrature, one track per step.
  assign phase_a = pos_reg[1] ^ pos_reg[0];
  assign phase_b = pos_reg[1];
endmodule : qce_enc_model

//--- qce_eval.sv
// Phase edge evaluation into up and down count pulses.
module qce_eval (
  input wire logic sys_clk,
  input wire logic reset,
  qce_phase_if.eval phase
);
  import qce_pkg::*;
  logic a_prev_reg;
  logic b_prev_reg;
  logic up_reg;
  logic down_reg;
  logic up_next;
  logic down_next;
  logic a_edge;
  logic b_edge;
  logic ab_diff;

  assign a_edge = phase.a_lvl ^ a_prev_reg;
  assign b_edge = phase.b_lvl ^ b_prev_reg;
  assign ab_diff = phase.a_lvl ^ phase.b_lvl;
  assign phase.up_pulse = up_reg;
  assign phase.down_pulse = down_reg;

  // In quadruple evaluation both phases moving in one cycle is illegal quadrature and is dropped.
  always_comb begin
    up_next = 1'b0;
    down_next = 1'b0;
    case (phase.mode)
      QCE_EVAL_DOUBLE: begin
        if (a_edge) begin
          up_next = ab_diff;
          down_next = ~ab_diff;
        end
      end
      QCE_EVAL_QUAD: begin
        if (a_edge && !b_edge) begin
          up_next = ab_diff;
          down_next = ~ab_diff;
        end else if (b_edge && !a_edge) begin
          up_next = ~ab_diff;
          down_next = ab_diff;
        end
      end
      default: begin
        if (a_edge && !phase.b_lvl) begin
          up_next = phase.a_lvl;
          down_next = ~phase.a_lvl;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      up_reg <= 1'b0;
      down_reg <= 1'b0;
    end else begin
      a_prev_reg <= phase.a_lvl;
      b_prev_reg <= phase.b_lvl;
      up_reg <= up_next;
      down_reg <= down_next;
    end
  end

  sequence s_single_a_rise_b_low;
    phase.mode == QCE_EVAL_SINGLE && phase.a_lvl && !a_prev_reg
      && !phase.b_lvl;
  endsequence

  chk_single_b_ignored: assert property (@(posedge sys_clk)
    disable iff (reset) (phase.mode == QCE_EVAL_SINGLE && !a_edge)
    |=> !up_reg && !down_reg)
    else $error("single evaluation counted without a phase A edge");
  chk_single_up_edge: assert property (@(posedge sys_clk)
    disable iff (reset) s_single_a_rise_b_low |=> up_reg && !down_reg)
    else $error("single evaluation missed an up pulse");
  chk_double_fall_low: assert property (@(posedge sys_clk)
    disable iff (reset) (phase.mode == QCE_EVAL_DOUBLE && !phase.a_lvl
    && a_prev_reg && !phase.b_lvl) |=> down_reg && !up_reg)
    else $error("double evaluation missed a down pulse");
  chk_quad_b_edge: assert property (@(posedge sys_clk)
    disable iff (reset) (phase.mode == QCE_EVAL_QUAD && b_edge && !a_edge)
    |=> (up_reg ^ down_reg))
    else $error("quadruple evaluation missed a phase B edge");
endmodule : qce_eval

//--- qce_phase_if.sv
// Phase levels, evaluation mode and count pulses between modules.
interface qce_phase_if;
  import qce_pkg::*;
  logic a_lvl;
  logic b_lvl;
  qce_eval_mode_e mode;
  logic up_pulse;
  logic down_pulse;
  modport eval (input a_lvl, input b_lvl, input mode,
                output up_pulse, output down_pulse);
  modport ctrl (output a_lvl, output b_lvl, output mode,
                input up_pulse, input down_pulse);
endinterface : qce_phase_if

//--- qce_pkg.sv
// Constants and types for the quadrature count evaluator.
package qce_pkg;
  localparam int unsigned QCE_CLK_FREQ_KHZ = 20000;
  localparam int unsigned QCE_PHASE_FREQ_MAX_KHZ = 500;
  localparam int unsigned QCE_DOUBLE_FREQ_MAX_KHZ = 1000;
  localparam int unsigned QCE_QUAD_FREQ_MAX_KHZ = 2000;
  localparam int unsigned QCE_QUAD_EDGE_CYCLES =
    QCE_CLK_FREQ_KHZ / QCE_QUAD_FREQ_MAX_KHZ;
  localparam int unsigned QCE_COUNT_W = 32;
  localparam int unsigned QCE_APB_AW = 8;
  localparam int unsigned QCE_SYNC_W = 3;
  localparam logic [7:0] QCE_CONFIG_OFS = 8'h00;
  localparam logic [7:0] QCE_CONTROL_OFS = 8'h04;
  localparam logic [7:0] QCE_STATUS_OFS = 8'h08;
  localparam logic [7:0] QCE_COUNT_OFS = 8'h0C;
  localparam logic [7:0] QCE_LATCH_OFS = 8'h10;
  localparam int unsigned QCE_CFG_MODE_LSB = 0;
  localparam int unsigned QCE_CFG_MODE_W = 2;
  localparam int unsigned QCE_CFG_FUNC_LSB = 2;
  localparam int unsigned QCE_CFG_FUNC_W = 3;
  localparam int unsigned QCE_CFG_GINV_BIT = 5;
  localparam int unsigned QCE_CFG_CNT_BIT = 6;
  localparam int unsigned QCE_CTL_GATE_BIT = 0;
  localparam int unsigned QCE_CTL_DIAG_BIT = 1;
  localparam int unsigned QCE_STS_SYNC_BIT = 0;
  localparam int unsigned QCE_STS_PERR_BIT = 1;
  localparam int unsigned QCE_STS_DIR_BIT = 2;
  localparam int unsigned QCE_STS_UP_BIT = 3;
  localparam int unsigned QCE_STS_DN_BIT = 4;
  localparam int unsigned QCE_STS_SIND_BIT = 5;
  localparam int unsigned QCE_STS_FAULT_BIT = 6;
  localparam int unsigned QCE_STS_INP_BIT = 7;
  typedef enum logic [1:0] {
    QCE_EVAL_SINGLE = 2'b00,
    QCE_EVAL_DOUBLE = 2'b01,
    QCE_EVAL_QUAD = 2'b10,
    QCE_EVAL_RSVD = 2'b11
  } qce_eval_mode_e;
  typedef enum logic [2:0] {
    QCE_DI_INPUT = 3'b000,
    QCE_DI_HARDWARE_GATE = 3'b001,
    QCE_DI_LATCH_RETRIG = 3'b010,
    QCE_DI_SYNC_RISE = 3'b011,
    QCE_DI_SYNC_ENABLE = 3'b100,
    QCE_DI_LATCH_RISE = 3'b101,
    QCE_DI_RSVD6 = 3'b110,
    QCE_DI_RSVD7 = 3'b111
  } qce_di_func_e;
  localparam qce_eval_mode_e QCE_MODE_RST = QCE_EVAL_SINGLE;
  localparam qce_di_func_e QCE_FUNC_RST = QCE_DI_INPUT;
  localparam logic QCE_BIT_RST = 1'b0;
  localparam logic QCE_DIR_RST = 1'b1;
  localparam logic [31:0] QCE_COUNT_RST = 32'h0000_0000;
endpackage : qce_pkg

//--- qce_sync.sv
// Three-stage input synchroniser with agreement filter.
module qce_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] dout_reg;
  logic [WIDTH-1:0] agree;

  assign agree = ~(ff2_reg ^ ff3_reg);
  assign dout = dout_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      dout_reg <= '0;
    end else begin
      ff1_reg <= din;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      dout_reg <= (ff3_reg & agree) | (dout_reg & ~agree);
    end
  end

  chk_sync_agree_only: assert property (
    @(posedge sys_clk) disable iff (reset)
    (dout_reg != $past(dout_reg)) |-> $past(ff2_reg == ff3_reg))
    else $error("synchronised level changed without stage agreement");
endmodule : qce_sync

//--- qce_top.sv
// Quadrature count evaluator with APB registers and status indicators.
module qce_top #(
  parameter int unsigned COUNT_W = qce_pkg::QCE_COUNT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qce_pkg::QCE_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic switched_input,
  output logic count_up_indicator,
  output logic count_down_indicator,
  output logic sync_indicator,
  output logic group_fault_indicator,
  output logic input_indicator,
  output logic param_error
);
  import qce_pkg::*;

  qce_phase_if phase_bus ();

  logic [QCE_SYNC_W-1:0] pin_raw;
  logic [QCE_SYNC_W-1:0] pin_lvl;
  logic sw_lvl;
  logic sw_prev_reg;
  logic sw_rise;

  qce_eval_mode_e cfg_mode_reg;
  qce_di_func_e cfg_func_reg;
  logic cfg_gate_inv_reg;
  logic cfg_count_mode_reg;
  logic ctl_gate_reg;
  logic ctl_diag_reg;
  logic param_assigned_reg;
  logic param_err_reg;
  logic param_err_next;

  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] latch_reg;
  logic dir_up_reg;
  logic sync_done_flag;
  logic gate_open;
  logic count_up;
  logic count_down;
  logic sync_evt;
  logic retrig_evt;
  logic latch_evt;

  logic up_ind_reg;
  logic dn_ind_reg;
  logic sync_ind_reg;
  logic fault_ind_reg;
  logic input_ind_reg;

  logic addr_hit;
  logic wr_en;
  logic rd_setup;
  logic sts_clr;
  logic [31:0] rd_data;
  logic [31:0] prdata_reg;

  assign pin_raw = {switched_input, phase_b, phase_a};

  qce_sync #(
    .WIDTH(QCE_SYNC_W)
  ) qce_sync_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(pin_raw),
    .dout(pin_lvl)
  );

  assign phase_bus.a_lvl = pin_lvl[0];
  assign phase_bus.b_lvl = pin_lvl[1];
  assign phase_bus.mode = cfg_mode_reg;
  assign sw_lvl = pin_lvl[2];

  qce_eval qce_eval_i (
    .sys_clk(sys_clk),
    .reset(reset),
    .phase(phase_bus.eval)
  );

  // APB decode: zero wait states, misaligned or unknown addresses error.
  always_comb begin
    case (paddr)
      QCE_CONFIG_OFS: addr_hit = 1'b1;
      QCE_CONTROL_OFS: addr_hit = 1'b1;
      QCE_STATUS_OFS: addr_hit = 1'b1;
      QCE_COUNT_OFS: addr_hit = 1'b1;
      QCE_LATCH_OFS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign wr_en = psel && penable && pwrite && addr_hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign sts_clr = wr_en && (paddr == QCE_STATUS_OFS)
    && pwdata[QCE_STS_SYNC_BIT];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_mode_reg <= QCE_MODE_RST;
      cfg_func_reg <= QCE_FUNC_RST;
      cfg_gate_inv_reg <= QCE_BIT_RST;
      cfg_count_mode_reg <= QCE_BIT_RST;
      param_assigned_reg <= QCE_BIT_RST;
    end else if (wr_en && paddr == QCE_CONFIG_OFS) begin
      cfg_mode_reg <= qce_eval_mode_e'(
        pwdata[QCE_CFG_MODE_LSB +: QCE_CFG_MODE_W]);
      cfg_func_reg <= qce_di_func_e'(
        pwdata[QCE_CFG_FUNC_LSB +: QCE_CFG_FUNC_W]);
      cfg_gate_inv_reg <= pwdata[QCE_CFG_GINV_BIT];
      cfg_count_mode_reg <= pwdata[QCE_CFG_CNT_BIT];
      param_assigned_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctl_gate_reg <= QCE_BIT_RST;
      ctl_diag_reg <= QCE_BIT_RST;
    end else if (wr_en && paddr == QCE_CONTROL_OFS) begin
      ctl_gate_reg <= pwdata[QCE_CTL_GATE_BIT];
      ctl_diag_reg <= pwdata[QCE_CTL_DIAG_BIT];
    end
  end

  // Reserved mode and function codes are treated as faulty settings too.
  always_comb begin
    param_err_next = 1'b0;
    if (cfg_gate_inv_reg && cfg_func_reg != QCE_DI_HARDWARE_GATE) begin
      param_err_next = 1'b1;
    end
    if (cfg_mode_reg == QCE_EVAL_RSVD) begin
      param_err_next = 1'b1;
    end
    if (cfg_func_reg == QCE_DI_RSVD6 || cfg_func_reg == QCE_DI_RSVD7) begin
      param_err_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      param_err_reg <= QCE_BIT_RST;
    end else begin
      param_err_reg <= param_err_next;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_prev_reg <= QCE_BIT_RST;
    end else begin
      sw_prev_reg <= sw_lvl;
    end
  end

  assign sw_rise = sw_lvl && !sw_prev_reg;
  assign sync_evt = sw_rise && (cfg_func_reg == QCE_DI_SYNC_RISE);
  assign retrig_evt = sw_rise && (cfg_func_reg == QCE_DI_LATCH_RETRIG);
  assign latch_evt = retrig_evt
    || (sw_rise && cfg_func_reg == QCE_DI_LATCH_RISE);

  // In gate mode the input level, after polarity, opens the gate.
  always_comb begin
    if (cfg_func_reg == QCE_DI_HARDWARE_GATE) begin
      gate_open = ctl_gate_reg && (sw_lvl ^ cfg_gate_inv_reg);
    end else begin
      gate_open = ctl_gate_reg;
    end
  end

  assign count_up = gate_open && phase_bus.up_pulse;
  assign count_down = gate_open && phase_bus.down_pulse;

  // A pulse every cycle is accepted, far above the fastest quadrature rate.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_reg <= COUNT_W'(QCE_COUNT_RST);
    end else if (sync_evt || retrig_evt) begin
      count_reg <= COUNT_W'(QCE_COUNT_RST);
    end else if (count_up) begin
      count_reg <= count_reg + 1'b1;
    end else if (count_down) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dir_up_reg <= QCE_DIR_RST;
    end else if (count_up) begin
      dir_up_reg <= 1'b1;
    end else if (count_down) begin
      dir_up_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_reg <= COUNT_W'(QCE_COUNT_RST);
    end else if (latch_evt) begin
      latch_reg <= count_reg;
    end
  end

  // A new synchronisation in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_done_flag <= QCE_BIT_RST;
    end else if (sync_evt) begin
      sync_done_flag <= 1'b1;
    end else if (sts_clr) begin
      sync_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      up_ind_reg <= QCE_BIT_RST;
      dn_ind_reg <= QCE_BIT_RST;
    end else begin
      up_ind_reg <= dir_up_reg && count_reg[0];
      dn_ind_reg <= !dir_up_reg && !count_reg[0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_ind_reg <= QCE_BIT_RST;
      fault_ind_reg <= QCE_BIT_RST;
      input_ind_reg <= QCE_BIT_RST;
    end else begin
      sync_ind_reg <= cfg_count_mode_reg && sync_done_flag;
      fault_ind_reg <= !param_assigned_reg || param_err_reg
        || ctl_diag_reg;
      input_ind_reg <= sw_lvl;
    end
  end

  assign count_up_indicator = up_ind_reg;
  assign count_down_indicator = dn_ind_reg;
  assign sync_indicator = sync_ind_reg;
  assign group_fault_indicator = fault_ind_reg;
  assign input_indicator = input_ind_reg;
  assign param_error = param_err_reg;

  always_comb begin
    rd_data = '0;
    case (paddr)
      QCE_CONFIG_OFS: begin
        rd_data[QCE_CFG_MODE_LSB +: QCE_CFG_MODE_W] = cfg_mode_reg;
        rd_data[QCE_CFG_FUNC_LSB +: QCE_CFG_FUNC_W] = cfg_func_reg;
        rd_data[QCE_CFG_GINV_BIT] = cfg_gate_inv_reg;
        rd_data[QCE_CFG_CNT_BIT] = cfg_count_mode_reg;
      end
      QCE_CONTROL_OFS: begin
        rd_data[QCE_CTL_GATE_BIT] = ctl_gate_reg;
        rd_data[QCE_CTL_DIAG_BIT] = ctl_diag_reg;
      end
      QCE_STATUS_OFS: begin
        rd_data[QCE_STS_SYNC_BIT] = sync_done_flag;
        rd_data[QCE_STS_PERR_BIT] = param_err_reg;
        rd_data[QCE_STS_DIR_BIT] = dir_up_reg;
        rd_data[QCE_STS_UP_BIT] = up_ind_reg;
        rd_data[QCE_STS_DN_BIT] = dn_ind_reg;
        rd_data[QCE_STS_SIND_BIT] = sync_ind_reg;
        rd_data[QCE_STS_FAULT_BIT] = fault_ind_reg;
        rd_data[QCE_STS_INP_BIT] = sw_lvl;
      end
      QCE_COUNT_OFS: begin
        rd_data[COUNT_W-1:0] = count_reg;
      end
      QCE_LATCH_OFS: begin
        rd_data[COUNT_W-1:0] = latch_reg;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_data;
    end
  end

  sequence s_sync_request;
    cfg_func_reg == QCE_DI_SYNC_RISE && sw_lvl && !sw_prev_reg;
  endsequence

  sequence s_sync_result;
    sync_done_flag && count_reg == '0;
  endsequence

  sequence s_gate_closed;
    cfg_func_reg == QCE_DI_HARDWARE_GATE && !(sw_lvl ^ cfg_gate_inv_reg);
  endsequence

  chk_param_err_flag: assert property (
    @(posedge sys_clk) disable iff (reset)
    (cfg_gate_inv_reg && cfg_func_reg != QCE_DI_HARDWARE_GATE)
    |=> param_err_reg ##1 fault_ind_reg)
    else $error("inverted gate polarity not flagged");
  chk_sync_load_flag: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_sync_request |=> s_sync_result)
    else $error("synchronisation did not clear count and set flag");
  chk_sync_set_wins: assert property (
    @(posedge sys_clk) disable iff (reset)
    (sync_evt && sts_clr) |=> sync_done_flag)
    else $error("sync flag lost when set and clear coincide");
  chk_sync_ind_mode: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!cfg_count_mode_reg ##1 !cfg_count_mode_reg) |-> !sync_ind_reg)
    else $error("sync indicator lit outside counting mode");
  chk_fault_unassigned: assert property (@(posedge sys_clk)
    disable iff (reset) (!param_assigned_reg || ctl_diag_reg)
    |=> fault_ind_reg)
    else $error("group fault indicator dark with fault present");
  chk_up_indicator: assert property (
    @(posedge sys_clk) disable iff (reset)
    (dir_up_reg && count_reg[0]) |=> up_ind_reg && !dn_ind_reg)
    else $error("up indicator does not follow low count bit");
  chk_down_indicator: assert property (@(posedge sys_clk)
    disable iff (reset) (!dir_up_reg && !count_reg[0])
    |=> dn_ind_reg && !up_ind_reg)
    else $error("down indicator does not follow inverted low bit");
  chk_count_step: assert property (
    @(posedge sys_clk) disable iff (reset)
    (count_up && !sync_evt && !retrig_evt)
    |=> count_reg == $past(count_reg) + 1'b1)
    else $error("count did not advance on an up pulse");
  chk_gate_hold: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_gate_closed |=> $stable(count_reg))
    else $error("count moved while the hardware gate was closed");
  chk_apb_unmapped: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && penable && !addr_hit) |-> pslverr && pready)
    else $error("unmapped access not answered with an error");
endmodule : qce_top

//--- tb_quadrature_count_evaluator.sv
// Self-checking testbench for the quadrature count evaluator.
module tb_quadrature_count_evaluator;
  timeunit 1ns;
  timeprecision 1ps;
  import qce_pkg::*;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_cnt;
  logic phase_a, phase_b, switched_input, step, step_dir, err;
  logic count_up_indicator, count_down_indicator, sync_indicator;
  logic group_fault_indicator, input_indicator, param_error;
  int n_errors, n_compared;
  int fwd [3] = '{2, 3, 5};

  qce_top qce_top_i (.sys_clk(sys_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a(phase_a), .phase_b(phase_b),
    .switched_input(switched_input),
    .count_up_indicator(count_up_indicator),
    .count_down_indicator(count_down_indicator),
    .sync_indicator(sync_indicator),
    .group_fault_indicator(group_fault_indicator),
    .input_indicator(input_indicator), .param_error(param_error));

  qce_enc_model qce_enc_model_i (.sys_clk(sys_clk), .reset(reset),
    .step(step), .step_dir(step_dir), .phase_a(phase_a),
    .phase_b(phase_b));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_errors++;
        conclude();
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic move(input int n, input logic dir);
    // Ten cycles per track edge is the fastest rate the counter must take.
    repeat (n) begin
      @(posedge sys_clk);
      step <= 1'b1;
      step_dir <= dir;
      @(posedge sys_clk);
      step <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    repeat (10) @(posedge sys_clk);
  endtask : move

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, step, step_dir, switched_input} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    n_compared = 0;
    exp_cnt = 32'h0000_0000;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(group_fault_indicator), 32'h1);
    apb(1'b0, QCE_CONFIG_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test defaults done");

    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_0020);
    repeat (3) @(posedge sys_clk);
    chk(32'(param_error), 32'h1);
    chk(32'(group_fault_indicator), 32'h1);
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_0024);
    repeat (3) @(posedge sys_clk);
    chk(32'(param_error), 32'h0);
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk(32'(group_fault_indicator), 32'h0);
    apb(1'b1, QCE_CONTROL_OFS, 32'h0000_0002);
    repeat (3) @(posedge sys_clk);
    chk(32'(group_fault_indicator), 32'h1);
    apb(1'b1, QCE_CONTROL_OFS, 32'h0000_0001);
    $display("test parameters done");

    // Five steps each way give 2, 3 and 5 counts in the three modes.
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, QCE_CONFIG_OFS, 32'(m));
      move(5, 1'b1);
      exp_cnt = exp_cnt + 32'(fwd[m]);
      apb(1'b0, QCE_COUNT_OFS, 32'h0);
      chk(rd, exp_cnt);
      chk(32'(count_up_indicator), 32'(exp_cnt[0]));
      move(5, 1'b0);
      exp_cnt = exp_cnt - 32'(fwd[m]);
      apb(1'b0, QCE_COUNT_OFS, 32'h0);
      chk(rd, exp_cnt);
      chk(32'(count_down_indicator), 32'(!exp_cnt[0]));
    end
    $display("test evaluation done");

    move(1, 1'b1);
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_004C);
    switched_input <= 1'b1;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, QCE_COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, QCE_STATUS_OFS, 32'h0);
    chk(32'(rd[QCE_STS_SYNC_BIT]), 32'h1);
    chk(32'(sync_indicator), 32'h1);
    chk(32'(input_indicator), 32'h1);
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_000C);
    repeat (3) @(posedge sys_clk);
    chk(32'(sync_indicator), 32'h0);
    apb(1'b1, QCE_STATUS_OFS, 32'h0000_0001);
    apb(1'b0, QCE_STATUS_OFS, 32'h0);
    chk(32'(rd[QCE_STS_SYNC_BIT]), 32'h0);
    switched_input <= 1'b0;
    $display("test synchronization done");

    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_0016);
    move(1, 1'b1);
    switched_input <= 1'b1;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, QCE_LATCH_OFS, 32'h0);
    chk(rd, 32'h0000_0001);
    // Hardware gate: a closed gate holds the count, an open one passes it.
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_0006);
    switched_input <= 1'b0;
    move(1, 1'b1);
    apb(1'b0, QCE_COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_0001);
    switched_input <= 1'b1;
    move(1, 1'b1);
    apb(1'b0, QCE_COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_0002);
    // A rising input in retrigger mode latches the count and restarts it.
    apb(1'b1, QCE_CONFIG_OFS, 32'h0000_000A);
    switched_input <= 1'b0;
    repeat (10) @(posedge sys_clk);
    switched_input <= 1'b1;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, QCE_COUNT_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, QCE_LATCH_OFS, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0000_0000);
    $display("test latch and unmapped done");
    conclude();
  end
endmodule : tb_quadrature_count_evaluator
